/* ext_bus_monitor.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checks for the strobe and port pin block.
// ------------------------------------------------------------
module ext_bus_monitor (
  // Ports.
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] programCounter,
  input wire logic        externalFetchSelect,
  input wire logic        resetPin,
  input wire logic        internalReset,
  input wire logic        addrLatchPulse,
  input wire logic        programFetchStrobe_n,
  input wire logic        fetchExternal,
  input wire logic        extIrqZero,
  input wire logic [7:0]  thirdPortOut,
  input wire logic [7:0]  thirdPortOe,
  input wire logic [1:0]  fourthPortOut
);
  // One clock, idle in reset.
  default clocking mc @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Pins are only pulled low.
  out_low_only_a: assert property (thirdPortOut == 8'h00 && fourthPortOut == 2'h0)
    else $error("port pin driven high");
  // A clear latch hides the pin.
  gate_forced_a: assert property (thirdPortOe[2] [*3] |-> extIrqZero)
    else $error("input not gated");
  ale_single_a: assert property (addrLatchPulse |=> !addrLatchPulse)
    else $error("latch pulse too wide");
  fetch_single_a: assert property ($fell(programFetchStrobe_n) |=> programFetchStrobe_n)
    else $error("fetch strobe too wide");
  // Data and fetch strobes never overlap.
  data_skip_a: assert property (thirdPortOe[6] || thirdPortOe[7] |-> programFetchStrobe_n)
    else $error("fetch in data cycle");
  internal_quiet_a: assert property (!fetchExternal && !$past(fetchExternal) && !$past(fetchExternal, 2)
    |-> programFetchStrobe_n)
    else $error("fetch strobe internal");
  select_high_a: assert property (!$past(sys_rst) && $past(externalFetchSelect)
    |-> fetchExternal == ($past(programCounter) >= 16'h8000))
    else $error("bad source, select high");
  select_low_a: assert property (!$past(sys_rst) && !$past(externalFetchSelect) |-> fetchExternal)
    else $error("internal fetch with select low");
  reset_qualify_a: assert property ($rose(internalReset) |-> $past(resetPin, 8) && $past(resetPin, 2))
    else $error("unqualified reset");
endmodule

bind ext_bus_strobes ext_bus_monitor mon (
  .core_clk, .sys_rst, .programCounter, .externalFetchSelect, .resetPin, .internalReset,
  .addrLatchPulse, .programFetchStrobe_n, .fetchExternal, .extIrqZero, .thirdPortOut,
  .thirdPortOe, .fourthPortOut
);

/* ext_bus_pkg.sv */
package ext_bus_pkg;

  // Phase within the machine cycle.
  typedef logic [3:0] phase_t;

  // Kind of external data access under way.
  typedef enum logic [1:0] {
    XDATA_NONE,
    XDATA_STORE,
    XDATA_LOAD
  } xdata_t;

endpackage

/* ext_bus_regs.svh */
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses on the AXI4-Lite bus)
// ----------------------------------------------------------------------------
`define ADDR_THIRD_LATCH   8'h00
`define ADDR_FOURTH_LATCH  8'h04
`define ADDR_CTRL          8'h08
`define ADDR_STATUS        8'h0c
`define ADDR_THIRD_PINS    8'h10

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTRL_DOUBLE_SPEED  0
`define CTRL_LATCH_OFF     1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define LATCH_RESET_THIRD  8'hff
`define LATCH_RESET_FOURTH 2'h3
`define OSC_PER_MC_NORMAL  4'hc
`define OSC_PER_MC_DOUBLE  4'h6
`define RESET_MC_COUNT     2
`define FETCH_LIMIT        16'h8000
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* ext_bus_strobes.sv */
`timescale 1ns/1ps
`include "ext_bus_regs.svh"

// Operation
// - Latch one leaves only weak pull-up
// - Third port alternate routing bits zero-five
// - Bits six, seven carry data strobes
// - Fourth port carries CAN transmit, receive
// - Reset pin high two machine cycles
// - Pulse address latch each external access; with latchPulseOff set and internal fetches, data accesses get no pulse
// - Address latch twice per cycle, skip
// - Software may disable address latch
// - Fetch strobe twice per machine cycle
// - Data access skips two fetch strobes
// - No fetch strobe for internal fetches
// - Select high: below 8000H internal
// - Select low: all fetches external
// - Reset sets all port latches
module ext_bus_strobes (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core side: fetch and data access requests
  input  wire logic [15:0] programCounter,
  input  wire logic        fetchActive,
  input  wire logic        xdataStoreReq,
  input  wire logic        xdataLoadReq,
  // Core side: serial, timer, interrupt and CAN functions
  input  wire logic        serialTxOut,
  input  wire logic        serialRxOut,
  output logic             serialRxIn,
  output logic             extIrqZero,
  output logic             extIrqOne,
  output logic             firstCounterInput,
  output logic             secondCounterInput,
  input  wire logic        canTxOut,
  output logic             canRxIn,
  // Pins: external fetch select and reset
  input  wire logic        externalFetchSelect,
  input  wire logic        resetPin,
  output logic             internalReset,
  // Pins: strobes
  output logic             addrLatchPulse,
  output logic             programFetchStrobe_n,
  output logic             fetchExternal,
  // Pins: third port (open drain with weak pull-up)
  input  wire logic [7:0]  thirdPortIn,
  output logic [7:0]  thirdPortOut,
  output logic [7:0]  thirdPortOe,
  // Pins: fourth port
  input  wire logic [1:0]  fourthPortIn,
  output logic [1:0]  fourthPortOut,
  output logic [1:0]  fourthPortOe
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [7:0]            thirdLatch;         // Third port output latch.
  logic [1:0]            fourthLatch;        // Fourth port output latch.
  logic                  doubleSpeedMode;    // Six oscillator periods per machine cycle.
  logic                  latchPulseOff;      // Software turn-off of address latch pulse.
  logic [7:0]            thirdSync;          // Synchronised third port pins.
  logic [1:0]            fourthSync;         // Synchronised fourth port pins.
  logic                  resetSync;          // Synchronised reset pin.
  ext_bus_pkg::phase_t   phase;              // Oscillator period within machine cycle.
  ext_bus_pkg::phase_t   phaseLast;          // Final phase of the current cycle.
  logic                  phaseWrap;          // Last phase of a machine cycle.
  ext_bus_pkg::xdata_t   xdataKind;          // Data access in the current cycle.
  logic [4:0]            resetCount;         // Oscillator periods the pin has stayed high.
  logic [4:0]            resetNeeded;        // Periods in two machine cycles.
  logic                  storeStrobe_n;      // External data write strobe.
  logic                  loadStrobe_n;       // External data read strobe.
  logic [7:0]            thirdDrive;         // Level each third port pin is pulled to.
  logic [1:0]            fourthDrive;        // Level each fourth port pin is pulled to.
  logic                  awHeld;             // Write address taken, awaiting data.
  logic                  wHeld;              // Write data taken, awaiting address.
  logic [7:0]            awAddr;             // Held write address.
  logic [31:0]           wData;              // Held write data.
  logic [3:0]            wStrb;              // Held byte enables.
  logic [31:0]           next_rdata;         // Read mux output.
  logic                  next_rerr;          // Unmapped read.

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  // Every port pin and the reset pin pass two flops before any logic looks at them.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_third
      sync2 u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  (thirdPortIn[gi]),
        .syncOut  (thirdSync[gi])
      );
    end
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_fourth
      sync2 u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  (fourthPortIn[gi]),
        .syncOut  (fourthSync[gi])
      );
    end
  endgenerate

  sync2 u_reset_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (resetPin),
    .syncOut  (resetSync)
  );

  // ----------------------------------------------------------------------------
  // Reset pin qualification
  // ----------------------------------------------------------------------------
  // two machine cycles
  assign resetNeeded = doubleSpeedMode ? 5'(`OSC_PER_MC_DOUBLE * `RESET_MC_COUNT)
                                       : 5'(`OSC_PER_MC_NORMAL * `RESET_MC_COUNT);

  // counted synchronous sampling
  // A glitch shorter than two machine cycles restarts the count and is ignored.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetCount    <= 5'h00;
      internalReset <= 1'b0;
    end else if (!resetSync) begin
      resetCount    <= 5'h00;
      internalReset <= 1'b0;
    end else if (resetCount < resetNeeded) begin
      resetCount <= resetCount + 5'h01;
    end else begin
      internalReset <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Machine cycle sequencer
  // ----------------------------------------------------------------------------
  // twelve or six periods
  assign phaseLast = doubleSpeedMode ? (`OSC_PER_MC_DOUBLE - 4'h1) : (`OSC_PER_MC_NORMAL - 4'h1);
  assign phaseWrap = (phase >= phaseLast);

  // Each core_clk edge stands for one oscillator period.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 4'h0;
    end else if (internalReset || phaseWrap) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // A data access request is caught at the cycle boundary and owns the whole next cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xdataKind <= ext_bus_pkg::XDATA_NONE;
    end else if (internalReset) begin
      xdataKind <= ext_bus_pkg::XDATA_NONE;
    end else if (phaseWrap) begin
      if (xdataStoreReq) begin
        xdataKind <= ext_bus_pkg::XDATA_STORE;
      end else if (xdataLoadReq) begin
        xdataKind <= ext_bus_pkg::XDATA_LOAD;
      end else begin
        xdataKind <= ext_bus_pkg::XDATA_NONE;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Fetch source and strobes
  // ----------------------------------------------------------------------------
  // fetch source select
  // With the select low the address never matters; every fetch goes out.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetchExternal <= 1'b1;
    end else begin
      fetchExternal <= !externalFetchSelect || (programCounter >= `FETCH_LIMIT);
    end
  end

  // Address latch slots sit at phases 0 and half-cycle; fetch strobe follows each.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrLatchPulse       <= 1'b0;
      programFetchStrobe_n <= 1'b1;
    end else if (internalReset) begin
      addrLatchPulse       <= 1'b0;
      programFetchStrobe_n <= 1'b1;
    end else begin
      // address latch slots
      // The second slot is dropped during a data access so the data address can be latched alone.
      addrLatchPulse <= !(latchPulseOff && externalFetchSelect && !fetchExternal)
                        && ((phase == 4'h0)
                            || ((phase == (phaseLast >> 1)) && (xdataKind == ext_bus_pkg::XDATA_NONE)));
      programFetchStrobe_n <= !(fetchActive && fetchExternal
                                && (xdataKind == ext_bus_pkg::XDATA_NONE)
                                && ((phase == 4'h2) || (phase == ((phaseLast >> 1) + 4'h2))));
    end
  end

  // data memory strobes
  // Strobes cover the second half of the cycle so port 0 data is stable.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      storeStrobe_n <= 1'b1;
      loadStrobe_n  <= 1'b1;
    end else begin
      storeStrobe_n <= !((xdataKind == ext_bus_pkg::XDATA_STORE) && (phase > (phaseLast >> 1)));
      loadStrobe_n  <= !((xdataKind == ext_bus_pkg::XDATA_LOAD) && (phase > (phaseLast >> 1)));
    end
  end

  // ----------------------------------------------------------------------------
  // Port pins
  // ----------------------------------------------------------------------------
  // third port drive
  // A latch zero pulls low, except on bits 1 and 6, which follow only the alternate output; otherwise the alternate output or one.
  always_comb begin
    thirdDrive    = thirdLatch;
    thirdDrive[0] = thirdLatch[0] & serialRxOut;
    thirdDrive[1] = serialTxOut;
    thirdDrive[6] = storeStrobe_n;
    thirdDrive[7] = thirdLatch[7] & loadStrobe_n;
    fourthDrive   = fourthLatch;
    fourthDrive[0] = fourthLatch[0] & canTxOut;
  end

  // weak pull-up on one
  // A one is never driven; the pin floats to the pull-up so others may pull it low.
  assign thirdPortOut  = 8'h00;
  assign thirdPortOe   = ~thirdDrive;
  assign fourthPortOut = 2'h0;
  assign fourthPortOe  = ~fourthDrive;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serialRxIn         <= 1'b1;
      extIrqZero         <= 1'b1;
      extIrqOne          <= 1'b1;
      firstCounterInput  <= 1'b1;
      secondCounterInput <= 1'b1;
      canRxIn            <= 1'b1;
    end else begin
      serialRxIn         <= thirdSync[0] | ~thirdLatch[0];
      extIrqZero         <= thirdSync[2] | ~thirdLatch[2];
      extIrqOne          <= thirdSync[3] | ~thirdLatch[3];
      firstCounterInput  <= thirdSync[4] | ~thirdLatch[4];
      secondCounterInput <= thirdSync[5] | ~thirdLatch[5];
      canRxIn            <= fourthSync[1] | ~fourthLatch[1];
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;

  // Address and data are taken independently and joined here.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else if (awHeld && wHeld) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
    end
  end

  // latches reset to one
  // Both sys_rst and a qualified reset pin restore the latches.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thirdLatch      <= `LATCH_RESET_THIRD;
      fourthLatch     <= `LATCH_RESET_FOURTH;
      doubleSpeedMode <= 1'b0;
      latchPulseOff   <= 1'b0;
    end else if (internalReset) begin
      thirdLatch      <= `LATCH_RESET_THIRD;
      fourthLatch     <= `LATCH_RESET_FOURTH;
      doubleSpeedMode <= 1'b0;
      latchPulseOff   <= 1'b0;
    end else if (awHeld && wHeld && wStrb[0]) begin
      case (awAddr)
        `ADDR_THIRD_LATCH: begin
          thirdLatch <= wData[7:0];
        end
        `ADDR_FOURTH_LATCH: begin
          fourthLatch <= wData[1:0];
        end
        `ADDR_CTRL: begin
          doubleSpeedMode <= wData[`CTRL_DOUBLE_SPEED];
          latchPulseOff   <= wData[`CTRL_LATCH_OFF];
        end
        default: begin
        end
      endcase
    end
  end

  // Response: OKAY for mapped writable words, SLVERR otherwise.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (awHeld && wHeld) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ((awAddr == `ADDR_THIRD_LATCH) || (awAddr == `ADDR_FOURTH_LATCH)
                       || (awAddr == `ADDR_CTRL)) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Status shows the live latch and fetch strobes, fetch source, reset and machine phase.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (s_axi_araddr)
      `ADDR_THIRD_LATCH:  next_rdata[7:0] = thirdLatch;
      `ADDR_FOURTH_LATCH: next_rdata[1:0] = fourthLatch;
      `ADDR_CTRL:         next_rdata[1:0] = {latchPulseOff, doubleSpeedMode};
      `ADDR_STATUS:       next_rdata[7:0] = {phase, fetchExternal, internalReset,
                                             !programFetchStrobe_n, addrLatchPulse};
      `ADDR_THIRD_PINS:   next_rdata[9:0] = {fourthSync, thirdSync};
      default:            next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* ext_mem_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Far side: pull-ups, outside drivers and data memory strobes.
// ------------------------------------------------------------
module ext_mem_model (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Pull-low enables of the block and of outside devices.
  input  wire logic [7:0] thirdPortOe,
  input  wire logic [1:0] fourthPortOe,
  input  wire logic [9:0] extPull,
  // Resolved pin levels.
  output logic [7:0]      thirdPortIn,
  output logic [1:0]      fourthPortIn,
  // Store and load cycles seen by the memory.
  output logic [15:0]     storeCnt,
  output logic [15:0]     loadCnt
);
  logic [1:0] lastStrobe; // Strobe pin levels one cycle ago.

  // Any pull-low beats the weak pull-up
  // Any pull-low wins over the pull-up.
  assign thirdPortIn  = ~(thirdPortOe | extPull[7:0]);
  assign fourthPortIn = ~(fourthPortOe | extPull[9:8]);

  // Strobes start accesses
  // Each falling strobe edge is one byte.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastStrobe <= 2'h3;
      storeCnt   <= 16'h0000;
      loadCnt    <= 16'h0000;
    end else begin
      lastStrobe <= thirdPortIn[7:6];
      if (lastStrobe[0] && !thirdPortIn[6]) begin
        storeCnt <= storeCnt + 16'h0001;
      end
      if (lastStrobe[1] && !thirdPortIn[7]) begin
        loadCnt <= loadCnt + 16'h0001;
      end
    end
  end
endmodule

/* sync2.sv */
`timescale 1ns/1ps

// Two-stage synchroniser for one bit.
module sync2 (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Data
  input  wire logic asyncIn,
  output logic      syncOut
);

  // First stage; only the second stage reads it.
  logic stageOne;

  // ----------------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------------
  // Resets high so an idle quasi-bidirectional pin reads as one.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stageOne <= 1'b1;
      syncOut  <= 1'b1;
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule

/* tb.sv */
`timescale 1ns/1ps
`include "ext_bus_regs.svh"

// ------------------------------------------------------------
// Bench for the strobe and port pin block.
// ------------------------------------------------------------
module tb;
  logic        core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, thirdPortIn, thirdPortOut, thirdPortOe;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, fourthPortIn, fourthPortOut, fourthPortOe;
  logic [15:0] programCounter, storeCnt, loadCnt, s0, l0;
  logic        fetchActive, xdataStoreReq, xdataLoadReq, serialTxOut, serialRxOut, canTxOut, serialRxIn;
  logic        extIrqZero, extIrqOne, firstCounterInput, secondCounterInput, canRxIn, externalFetchSelect;
  logic        resetPin, internalReset, addrLatchPulse, programFetchStrobe_n, fetchExternal;
  logic [9:0]  extPull;
  int          error_cnt, cmp_count, a, f, a2, f2, i, k;
  logic [15:0] pcTab [4] = '{16'h1234, 16'h7fff, 16'h8000, 16'hffff};
  logic        selTab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int          fetchTab [4] = '{8, 0, 8, 8};
  int          pinIdx [6] = '{0, 2, 3, 4, 5, 9};
  wire [5:0]   altIns = {canRxIn, secondCounterInput, firstCounterInput, extIrqOne, extIrqZero, serialRxIn};

  ext_bus_strobes DUT (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .programCounter,
    .fetchActive, .xdataStoreReq, .xdataLoadReq, .serialTxOut, .serialRxOut, .serialRxIn, .extIrqZero,
    .extIrqOne, .firstCounterInput, .secondCounterInput, .canTxOut, .canRxIn, .externalFetchSelect, .resetPin,
    .internalReset, .addrLatchPulse, .programFetchStrobe_n, .fetchExternal, .thirdPortIn, .thirdPortOut,
    .thirdPortOe, .fourthPortIn, .fourthPortOut, .fourthPortOe);
  ext_mem_model mem (.core_clk, .sys_rst, .thirdPortOe, .fourthPortOe, .extPull, .thirdPortIn, .fourthPortIn,
    .storeCnt, .loadCnt);

  // The 40 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Counts and reports one comparison.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Both write channels offered together; ready lines stay high.
  task automatic axi_wr(input logic [7:0] adr, input logic [31:0] dat, output logic [1:0] rsp);
    logic aw = 1'b0;
    logic w = 1'b0;
    s_axi_awaddr <= adr;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] adr, output logic [31:0] dat, output logic [1:0] rsp);
    s_axi_araddr <= adr;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Counts latch pulses and fetch strobes.
  task automatic count(input int n, output int al, output int fs);
    al = 0;
    fs = 0;
    repeat (n) begin
      @(posedge core_clk);
      al += int'(addrLatchPulse === 1'b1);
      fs += int'(programFetchStrobe_n === 1'b0);
    end
  endtask

  // A hang ends the run as a failure.
  initial begin
    #100us;
    error_cnt++;
    report_and_stop();
  end

  // Windows span whole machine cycles, so start phase is moot.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {xdataStoreReq, xdataLoadReq, resetPin, externalFetchSelect} = 4'h0;
    {fetchActive, serialTxOut, serialRxOut, canTxOut} = 4'hf;
    programCounter = 16'h0000;
    extPull = 10'h000;
    sys_rst = 1'b1;
    cycles(2);
    sys_rst <= 1'b0;
    cycles(1);
    axi_rd(`ADDR_THIRD_LATCH, d, r);
    chk(d, 32'hff);
    axi_rd(`ADDR_FOURTH_LATCH, d, r);
    chk(d, 32'h3);
    axi_rd(8'h14, d, r);
    chk({d[29:0], r}, {30'h0, `RESP_SLVERR});
    axi_wr(8'h14, 32'h0, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    for (k = 0; k < 4; k++) begin
      externalFetchSelect <= selTab[k];
      programCounter <= pcTab[k];
      cycles(3);
      count(48, a, f);
      chk(32'(f), 32'(fetchTab[k]));
      chk(32'(a), 32'd8);
    end
    for (k = 0; k < 2; k++) begin
      s0 = storeCnt;
      l0 = loadCnt;
      xdataStoreReq <= (k == 0);
      xdataLoadReq <= (k == 1);
      count(12, a, f);
      xdataStoreReq <= 1'b0;
      xdataLoadReq <= 1'b0;
      count(36, a2, f2);
      chk(32'(a + a2), 32'd7);
      chk(32'(f + f2), 32'd6);
      chk({storeCnt - s0, loadCnt - l0}, (k == 0) ? 32'h10000 : 32'h1);
    end
    externalFetchSelect <= 1'b1;
    programCounter <= 16'h0100;
    axi_wr(`ADDR_CTRL, 32'h1 << `CTRL_LATCH_OFF, r);
    cycles(3);
    count(48, a, f);
    chk(32'(a), 32'd0);
    externalFetchSelect <= 1'b0;
    cycles(3);
    count(48, a, f);
    chk(32'(a), 32'd8);
    axi_wr(`ADDR_CTRL, 32'h1 << `CTRL_DOUBLE_SPEED, r);
    cycles(12);
    count(48, a, f);
    chk({16'(a), 16'(f)}, 32'h00100010);
    axi_wr(`ADDR_CTRL, 32'h0, r);
    for (k = 0; k < 6; k++) begin
      extPull <= 10'h001 << pinIdx[k];
      cycles(5);
      chk({26'h0, altIns}, {26'h0, 6'h3f & ~(6'h01 << k)});
    end
    extPull <= 10'h23d;
    serialTxOut <= 1'b0;
    canTxOut <= 1'b0;
    axi_wr(`ADDR_THIRD_LATCH, 32'hc3, r);
    axi_wr(`ADDR_FOURTH_LATCH, 32'h1, r);
    cycles(5);
    chk({26'h0, altIns}, 32'h3e);
    chk({22'h0, thirdPortOe, fourthPortOe}, 32'hfb);
    extPull <= 10'h000;
    serialTxOut <= 1'b1;
    canTxOut <= 1'b1;
    cycles(5);
    axi_rd(`ADDR_THIRD_PINS, d, r);
    chk(d, 32'h1c3);
    resetPin <= 1'b1;
    cycles(10);
    chk({31'h0, internalReset}, 32'h0);
    resetPin <= 1'b0;
    cycles(6);
    resetPin <= 1'b1;
    i = 0;
    do begin
      cycles(1);
      i++;
    end while (internalReset !== 1'b1 && i < 40);
    chk(32'(i >= 24 && i < 32), 32'h1);
    cycles(4);
    resetPin <= 1'b0;
    cycles(8);
    axi_rd(`ADDR_THIRD_LATCH, d, r);
    chk(d, 32'hff);
    axi_rd(`ADDR_FOURTH_LATCH, d, r);
    chk(d, 32'h3);
    report_and_stop();
  end
endmodule
